// [icp_pkg.sv]
// constants, types and helper functions of the instrument command parser
package icp_pkg;
  localparam logic [6:0] ICP_MAX_LEN = 7'h50; // 80 characters per line
  localparam logic [6:0] ICP_CNT_RST = 7'h00; // counters after reset
  localparam logic [1:0] ICP_FIFO_DEPTH = 2'h2; // output buffer entries
  localparam logic [7:0] CH_NL = 8'h0A; // new line / line feed
  localparam logic [7:0] CH_CR = 8'h0D; // carriage return
  localparam logic [7:0] CH_SP = 8'h20; // space
  localparam logic [7:0] CH_COMMA = 8'h2C; // argument separator
  localparam logic [7:0] CH_SEMI = 8'h3B; // command separator
  localparam logic [7:0] CH_QUERY = 8'h3F; // query mark
  localparam logic [7:0] CH_ONE = 8'h31; // numeric on
  localparam logic [7:0] CH_ZERO = 8'h30; // numeric off
  // token kinds handed to the executor
  typedef enum logic [1:0] {
    TK_HDR = 2'b00, TK_ARG = 2'b01, TK_END = 2'b10, TK_EOM = 2'b11
  } icp_kind_t;
  // system level plus the eight subsystems
  typedef enum logic [3:0] {
    SUB_SYS = 4'h0, SUB_NUM = 4'h1, SUB_GRAP = 4'h2, SUB_MEAS = 4'h3, SUB_INP = 4'h4,
    SUB_PROC = 4'h5, SUB_IST = 4'h6, SUB_INT = 4'h7, SUB_DIAG = 4'h8
  } icp_sub_t;
  // one byte from the bus front end
  typedef struct packed {
    logic [7:0] data; // ascii byte
    logic eoi; // end signal with this byte
  } icp_rx_t;
  // one decoded token
  typedef struct packed {
    icp_kind_t kind; // header, argument, end of command, end of message
    icp_sub_t sub; // subsystem in force
    logic query; // header ended in a query mark
    logic setup; // setup save or restore header
    logic err; // syntax fault, execution stops here
    logic [2:0] len; // valid characters in text
    logic [3:0][7:0] text; // upper case, text[0] first
  } icp_tok_t;
  localparam logic [3:0][7:0] TXT_NULL = 32'h00000000; // empty text
  // case folding and classification of letters
  function automatic logic [7:0] icp_upcase(input logic [7:0] c);
    icp_upcase = (c >= 8'h61 && c <= 8'h7A) ? (c - 8'h20) : c;
  endfunction : icp_upcase
  function automatic logic icp_vowel(input logic [7:0] c);
    icp_vowel = (c == 8'h41) || (c == 8'h45) || (c == 8'h49) || (c == 8'h4F) || (c == 8'h55);
  endfunction : icp_vowel
  function automatic logic icp_letter(input logic [7:0] c);
    icp_letter = (c >= 8'h41 && c <= 8'h5A);
  endfunction : icp_letter
endpackage : icp_pkg

// [icp_parser.sv]
// message buffer, tokenizer and output buffer of the command parser
`timescale 1ns/10ps
module icp_parser
  import icp_pkg::*;
(
  input wire logic sys_clk, // 50 MHz clock
  input wire logic rstn, // async reset, low
  input wire logic rx_valid, // byte offered
  input wire icp_rx_t rx, // byte and end signal
  output logic rx_ready, // byte taken when high
  output icp_tok_t tok, // token to executor
  output logic tok_valid, // token offered
  input wire logic tok_ready, // executor takes token
  input wire logic exec_err, // executor found faulty command
  output logic busy, // message being executed
  output logic ovf_err, // last line was truncated
  output logic syn_err, // last message hit syntax fault
  output logic exe_err // last message stopped by executor
);
  typedef enum logic [0:0] {S_RX = 1'b0, S_SCAN = 1'b1} icp_st_t;
  icp_st_t st_q, st_d; // receive or execute
  logic [7:0] mem_q [0:79], mem_d [0:79]; // message buffer
  logic [6:0] wr_q, wr_d; // write index
  logic [6:0] crs_q, crs_d; // start of carriage return run
  logic cr_q, cr_d; // inside a carriage return run
  logic [6:0] len_q, len_d; // buffered message length
  logic [6:0] rd_q, rd_d; // scan index
  logic [6:0] tcnt_q, tcnt_d; // characters in current token
  logic [3:0][7:0] acc_q, acc_d; // first characters of token
  logic qm_q, qm_d; // token carried a query mark
  logic hdr_q, hdr_d; // next token is a header
  logic open_q, open_d; // header sent, end not yet
  icp_sub_t sub_q, sub_d; // subsystem in force, kept across lines
  logic ovf_q, ovf_d, syn_q, syn_d, exe_q, exe_d; // fault flags
  // two entry output buffer
  icp_tok_t fq_q [0:1], fq_d [0:1]; // entries
  logic wp_q, wp_d, rp_q, rp_d; // pointers
  logic [1:0] cnt_q, cnt_d; // occupancy
  logic push; // scanner writes a token
  logic flush; // fault drops queued tokens
  icp_tok_t nt; // token being written
  logic in_ready; // buffer has room
  logic [7:0] c, ch; // received byte, scanned byte
  logic at_end, is_sep, is_semi; // scan classification
  logic [2:0] slen; // shortform length
  logic [3:0][7:0] stxt; // shortform text
  icp_sub_t hsub; // subsystem named by header
  logic [31:0] srev, arev; // shortform and token text in reading order

  // text[0] holds the first character, while a string literal puts its first character on top;
  // turning the bytes round lets the decode compare against plain literals
  function automatic logic [31:0] icp_rev(input logic [3:0][7:0] t);
    icp_rev = {t[0], t[1], t[2], t[3]};
  endfunction : icp_rev
  assign srev = icp_rev(stxt);
  assign arev = icp_rev(acc_q);

  assign in_ready = (cnt_q != ICP_FIFO_DEPTH);
  assign tok_valid = (cnt_q != 2'h0);
  assign tok = fq_q[rp_q];
  assign rx_ready = (st_q == S_RX); // buffer locked while executing
  assign busy = (st_q == S_SCAN);
  assign ovf_err = ovf_q;
  assign syn_err = syn_q;
  assign exe_err = exe_q;
  assign c = icp_upcase(rx.data);
  assign ch = icp_upcase(mem_q[rd_q[6:0] < ICP_MAX_LEN ? rd_q : ICP_CNT_RST]);
  assign at_end = (rd_q == len_q);
  assign is_sep = (ch == CH_SP) || (ch == CH_COMMA);
  assign is_semi = (ch == CH_SEMI);

  // shortform of the collected header
  always_comb begin
    slen = (tcnt_q > 7'h04) ? 3'h4 : tcnt_q[2:0];
    if (tcnt_q >= 7'h04 && icp_vowel(acc_q[3])) begin
      slen = 3'h3;
    end
    stxt = acc_q;
    if (slen == 3'h3) begin
      stxt[3] = 8'h00; // cut to three characters
    end
  end

  // subsystem selector decode on the shortform
  always_comb begin
    case (srev)
      {"NUM", 8'h00}: hsub = SUB_NUM;
      "GRAP": hsub = SUB_GRAP;
      "MEAS": hsub = SUB_MEAS;
      "PRET": hsub = SUB_MEAS;
      {"INP", 8'h00}: hsub = SUB_INP;
      "PROC": hsub = SUB_PROC;
      {"IST", 8'h00}: hsub = SUB_IST;
      {"INT", 8'h00}: hsub = SUB_INT;
      "DIAG": hsub = SUB_DIAG;
      default: hsub = sub_q; // a command keeps the current subsystem
    endcase
  end

  // receive and scan next state
  always_comb begin
    st_d = st_q;
    mem_d = mem_q;
    wr_d = wr_q;
    crs_d = crs_q;
    cr_d = cr_q;
    len_d = len_q;
    rd_d = rd_q;
    tcnt_d = tcnt_q;
    acc_d = acc_q;
    qm_d = qm_q;
    hdr_d = hdr_q;
    open_d = open_q;
    sub_d = sub_q;
    ovf_d = ovf_q;
    syn_d = syn_q;
    exe_d = exe_q;
    push = 1'b0;
    flush = 1'b0;
    nt = '{kind: TK_EOM, sub: sub_q, query: 1'b0, setup: 1'b0, err: 1'b0, len: 3'h0, text: TXT_NULL};
    case (st_q)
      S_RX: begin
        if (rx_valid) begin
          if (wr_q == ICP_CNT_RST && !cr_q) begin
            ovf_d = 1'b0; // new line clears old faults
            syn_d = 1'b0;
            exe_d = 1'b0;
          end
          if (c == CH_NL) begin
            len_d = cr_q ? crs_q : wr_q;
            st_d = S_SCAN;
          end else begin
            if (wr_q < ICP_MAX_LEN) begin
              mem_d[wr_q] = c;
              wr_d = wr_q + 7'h01;
            end else begin
              ovf_d = 1'b1;
            end
            if (c == CH_CR) begin
              if (!cr_q) begin
                crs_d = wr_q;
              end
              cr_d = 1'b1;
            end else begin
              cr_d = 1'b0;
            end
            if (rx.eoi) begin
              len_d = (wr_q < ICP_MAX_LEN) ? wr_q + 7'h01 : wr_q;
              st_d = S_SCAN;
            end
          end
          if (st_d == S_SCAN) begin
            wr_d = ICP_CNT_RST;
            cr_d = 1'b0;
            rd_d = ICP_CNT_RST;
            tcnt_d = ICP_CNT_RST;
            acc_d = TXT_NULL;
            qm_d = 1'b0;
            hdr_d = 1'b1;
            open_d = 1'b0;
          end
        end
      end
      S_SCAN: begin
        if (exec_err) begin
          exe_d = 1'b1;
          flush = 1'b1;
          st_d = S_RX;
        end else if (in_ready) begin
          if ((at_end || is_sep || is_semi) && tcnt_q != ICP_CNT_RST) begin
            push = 1'b1; // one token per scan step
            tcnt_d = ICP_CNT_RST;
            acc_d = TXT_NULL;
            qm_d = 1'b0;
            nt.query = qm_q;
            if (hdr_q) begin
              nt.kind = TK_HDR;
              nt.len = slen;
              nt.text = stxt;
              nt.sub = hsub;
              sub_d = hsub;
              nt.setup = (srev == {"SET", 8'h00});
              hdr_d = 1'b0;
              open_d = 1'b1;
              if (!icp_letter(acc_q[0])) begin
                nt.err = 1'b1;
                syn_d = 1'b1;
                st_d = S_RX;
              end
            end else begin
              nt.kind = TK_ARG;
              nt.len = slen > 3'h3 || tcnt_q > 7'h03 ? 3'h4 : tcnt_q[2:0];
              nt.text = acc_q;
              if (sub_q != SUB_GRAP && (arev == {"OFF", 8'h00} || arev == {"ON", 16'h0000})) begin
                nt.len = 3'h1;
                // digit goes in the first character slot
                nt.text = {24'h000000, (acc_q[1] == 8'h4E) ? CH_ONE : CH_ZERO};
              end
            end
          end else if ((at_end || is_semi) && open_q) begin
            push = 1'b1;
            nt.kind = TK_END;
            open_d = 1'b0;
            hdr_d = 1'b1;
            if (!at_end) begin
              rd_d = rd_q + 7'h01;
            end
          end else if (at_end) begin
            push = 1'b1;
            nt.kind = TK_EOM;
            st_d = S_RX;
          end else begin
            rd_d = rd_q + 7'h01;
            if (!is_sep && !is_semi) begin
              if (ch == CH_QUERY) begin
                qm_d = 1'b1;
              end else if (tcnt_q < 7'h04) begin
                acc_d[tcnt_q[1:0]] = ch;
              end
              if (ch != CH_QUERY && tcnt_q != ICP_MAX_LEN) begin
                tcnt_d = tcnt_q + 7'h01;
              end
            end
          end
        end
      end
      default: st_d = S_RX;
    endcase
  end

  // output buffer next state
  always_comb begin
    fq_d = fq_q;
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (flush) begin
      cnt_d = 2'h0; // queued later commands never run
      rp_d = wp_q;
    end else begin
      if (push) begin
        fq_d[wp_q] = nt;
        wp_d = ~wp_q;
      end
      if (tok_valid && tok_ready) begin
        rp_d = ~rp_q;
      end
      cnt_d = cnt_q + {1'b0, push} - {1'b0, tok_valid && tok_ready};
    end
  end

  // state registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= S_RX;
      for (int i = 0; i < 80; i++) begin
        mem_q[i] <= 8'h00;
      end
      wr_q <= ICP_CNT_RST;
      crs_q <= ICP_CNT_RST;
      cr_q <= 1'b0;
      len_q <= ICP_CNT_RST;
      rd_q <= ICP_CNT_RST;
      tcnt_q <= ICP_CNT_RST;
      acc_q <= TXT_NULL;
      qm_q <= 1'b0;
      hdr_q <= 1'b1;
      open_q <= 1'b0;
      sub_q <= SUB_SYS;
      ovf_q <= 1'b0;
      syn_q <= 1'b0;
      exe_q <= 1'b0;
      fq_q[0] <= '0;
      fq_q[1] <= '0;
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      st_q <= st_d;
      mem_q <= mem_d;
      wr_q <= wr_d;
      crs_q <= crs_d;
      cr_q <= cr_d;
      len_q <= len_d;
      rd_q <= rd_d;
      tcnt_q <= tcnt_d;
      acc_q <= acc_d;
      qm_q <= qm_d;
      hdr_q <= hdr_d;
      open_q <= open_d;
      sub_q <= sub_d;
      ovf_q <= ovf_d;
      syn_q <= syn_d;
      exe_q <= exe_d;
      fq_q <= fq_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end
endmodule : icp_parser

// [icp_parser_assertions.sv]
// port checks of the command parser
`timescale 1ns/10ps
module icp_parser_assertions
  import icp_pkg::*;
(
  input wire logic sys_clk, // clock
  input wire logic rstn, // reset, low
  input wire logic rx_valid, // byte offered
  input wire icp_rx_t rx, // byte and end flag
  input wire logic rx_ready, // byte taken
  input wire icp_tok_t tok, // token
  input wire logic tok_valid, // token offered
  input wire logic tok_ready, // token taken
  input wire logic exec_err, // executor fault
  input wire logic busy, // executing
  input wire logic ovf_err, // line cut
  input wire logic syn_err, // syntax fault
  input wire logic exe_err // executor stop
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic take_w; // byte accepted
  assign take_w = rx_valid && rx_ready;
  a_nl_ends_msg: assert property (take_w && rx.data == CH_NL |=> !rx_ready && busy)
    else $error("receive open after new line");
  a_eoi_ends_msg: assert property (take_w && rx.eoi |=> !rx_ready && busy)
    else $error("receive open after end signal");
  a_busy_no_rx: assert property (busy |-> !rx_ready)
    else $error("byte accepted while executing");
  a_no_early_tok: assert property ($rose(tok_valid) |-> $past(busy))
    else $error("token before message complete");
  a_tok_holds: assert property (tok_valid && !tok_ready && !(busy && exec_err) |=> tok_valid && $stable(tok))
    else $error("stalled token changed");
  a_exec_flush: assert property (busy && exec_err |=> !tok_valid && rx_ready && exe_err)
    else $error("executor fault did not stop message");
  a_ovf_cause: assert property ($rose(ovf_err) |-> $past(take_w))
    else $error("overflow without a byte");
  a_upper_hdr: assert property (tok_valid && tok.kind == TK_HDR |-> !(tok.text[0] inside {[8'h61:8'h7A]}))
    else $error("lower case header");
  a_hdr_len: assert property (tok_valid |-> tok.len <= 3'h4 && tok.sub <= SUB_DIAG)
    else $error("token length or subsystem out of range");
endmodule : icp_parser_assertions

// [icp_host.sv]
// remote controller model: sends program messages a byte at a time
`timescale 1ns/10ps
module icp_host
  import icp_pkg::*;
(
  input wire logic sys_clk, // parser clock
  input wire logic rx_ready, // parser takes byte
  output logic rx_valid, // byte offered
  output icp_rx_t rx // byte and end flag
);
  initial begin
    rx_valid = 1'b0;
    rx = '0;
  end
  // byte held until taken at a rising edge; separators come from caller text
  task automatic send(input string s, input logic eoi_last);
    for (int i = 0; i < s.len(); i++) begin
      @(negedge sys_clk);
      rx_valid = 1'b1;
      rx.data = s[i];
      rx.eoi = eoi_last && (i == s.len() - 1);
      while (rx_ready !== 1'b1) @(negedge sys_clk);
      @(posedge sys_clk);
    end
    @(negedge sys_clk);
    rx_valid = 1'b0;
    rx = ~rx; // released bus must not look like the last byte
  endtask : send
endmodule : icp_host

// [tb_icp_parser.sv]
// self-checking bench of the command parser
`timescale 1ns/10ps
module tb_icp_parser;
  import icp_pkg::*;
  logic sys_clk = 1'b0; // 50 MHz
  logic rstn = 1'b0; // reset, low
  logic rx_valid; // from host model
  icp_rx_t rx; // from host model
  logic rx_ready, tok_valid, busy, ovf_err, syn_err, exe_err; // parser outputs
  icp_tok_t tok; // token out
  logic tok_ready = 1'b1; // executor takes tokens
  logic exec_err = 1'b0; // executor fault pulse
  icp_tok_t q[$]; // tokens taken
  icp_tok_t eq[$]; // tokens expected
  int bad_count = 0;
  int compares = 0;
  always #10 sys_clk = ~sys_clk;
  icp_parser u_dut (.sys_clk(sys_clk), .rstn(rstn), .rx_valid(rx_valid), .rx(rx), .rx_ready(rx_ready), .tok(tok),
    .tok_valid(tok_valid), .tok_ready(tok_ready), .exec_err(exec_err), .busy(busy), .ovf_err(ovf_err),
    .syn_err(syn_err), .exe_err(exe_err));
  icp_host u_host (.sys_clk(sys_clk), .rx_ready(rx_ready), .rx_valid(rx_valid), .rx(rx));
  // executor side: record each token taken
  always @(posedge sys_clk) begin
    if (tok_valid === 1'b1 && tok_ready) q.push_back(tok);
  end
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // expected token; end markers are judged by kind only
  task automatic e(input icp_kind_t k, input icp_sub_t s = SUB_SYS, input string t = "", input logic qy = 1'b0);
    icp_tok_t x;
    x = '0;
    x.kind = k;
    x.sub = s;
    x.query = qy;
    x.setup = (k == TK_HDR) && (t == "SET");
    x.len = 3'(t.len());
    for (int i = 0; i < t.len(); i++) x.text[i] = t[i];
    eq.push_back(x);
  endtask : e
  // wait for idle, then compare tokens in arrival order
  task automatic settle_cmp(input string what);
    repeat (3) @(negedge sys_clk);
    while (!(rx_ready === 1'b1 && tok_valid === 1'b0 && busy === 1'b0)) @(negedge sys_clk);
    if (eq.size() != 0) begin
      chk({what, " count"}, q.size(), eq.size());
      foreach (eq[i]) begin
        if (i >= q.size()) break;
        if (eq[i].kind inside {TK_END, TK_EOM}) chk(what, q[i].kind, eq[i].kind);
        else chk(what, q[i], eq[i]);
      end
      q.delete();
      eq.delete();
    end
  endtask : settle_cmp
  task automatic t_subs;
    string nm[8] = '{"NUM", "GRAP", "MEAS", "INP", "PROC", "IST", "INT", "DIAG"};
    string s;
    s = "";
    for (int i = 0; i < 8; i++) begin
      s = {s, nm[i], (i == 7) ? "\n" : ";"};
      e(TK_HDR, icp_sub_t'(i + 1), nm[i]);
      e(TK_END);
    end
    e(TK_EOM);
    u_host.send(s, 1'b0);
    settle_cmp("subsystems");
  endtask : t_subs
  task automatic t_args;
    u_host.send("meas freq,on\n", 1'b0);
    e(TK_HDR, SUB_MEAS, "MEAS");
    e(TK_ARG, SUB_MEAS, "FREQ");
    e(TK_ARG, SUB_MEAS, "1");
    e(TK_END);
    e(TK_EOM);
    settle_cmp("arguments");
  endtask : t_args
  task automatic t_seps;
    u_host.send("PRET;inp a b\r\r\n", 1'b0);
    e(TK_HDR, SUB_MEAS, "PRET");
    e(TK_END);
    e(TK_HDR, SUB_INP, "INP");
    e(TK_ARG, SUB_INP, "A");
    e(TK_ARG, SUB_INP, "B");
    e(TK_END);
    e(TK_EOM);
    settle_cmp("separators");
  endtask : t_seps
  task automatic t_eoi;
    u_host.send("DIAG;ARMING", 1'b1);
    e(TK_HDR, SUB_DIAG, "DIAG");
    e(TK_END);
    e(TK_HDR, SUB_DIAG, "ARM");
    e(TK_END);
    e(TK_EOM);
    settle_cmp("end signal");
    u_host.send("SETUP?\n", 1'b0);
    e(TK_HDR, SUB_DIAG, "SET", 1'b1);
    e(TK_END);
    e(TK_EOM);
    settle_cmp("setup");
  endtask : t_eoi
  // executor faults the second command while the first is done
  task automatic t_flush;
    tok_ready = 1'b0;
    u_host.send("NUM;GRAP;INP\n", 1'b0);
    repeat (4) @(negedge sys_clk);
    chk("stalled tokens", tok_valid, 1'b1);
    tok_ready = 1'b1;
    while (!(q.size() != 0 && q[$].kind === TK_END)) @(negedge sys_clk);
    tok_ready = 1'b0;
    exec_err = 1'b1;
    @(negedge sys_clk);
    exec_err = 1'b0;
    tok_ready = 1'b1;
    e(TK_HDR, SUB_NUM, "NUM");
    e(TK_END);
    settle_cmp("fault stop");
    chk("exe_err", exe_err, 1'b1);
  endtask : t_flush
  // boundary of the line length and a bad header
  task automatic t_limits;
    string s;
    for (int n = 80; n <= 81; n++) begin
      s = "";
      repeat (n) s = {s, "B"};
      u_host.send({s, "\n"}, 1'b0);
      settle_cmp("long line");
      chk("ovf_err", ovf_err, n > 80);
      q.delete();
    end
    u_host.send("1X\n", 1'b0);
    settle_cmp("syntax");
    chk("syn_err", syn_err, 1'b1);
    chk("bad header flag", (q.size() != 0) ? q[0].err : 1'b0, 1'b1);
    q.delete();
  endtask : t_limits
  task automatic final_report;
    if (bad_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (4) @(negedge sys_clk);
    rstn = 1'b1;
    t_subs();
    t_args();
    t_seps();
    t_eoi();
    t_flush();
    t_limits();
    final_report();
  end
  // hang guard, far beyond the several hundred cycles needed
  initial begin
    #400000;
    bad_count++;
    final_report();
  end
endmodule : tb_icp_parser
bind icp_parser icp_parser_assertions u_chk (.sys_clk, .rstn, .rx_valid, .rx, .rx_ready, .tok, .tok_valid,
  .tok_ready, .exec_err, .busy, .ovf_err, .syn_err, .exe_err);
